// ===== design/cfe_pkg.sv
/*
  Shared constants for the CSI-2 forwarding engine: register offsets and
  field positions, reset values, packet and mode encodings, buffer sizes
  and the sync window.
  Assumes a 100 MHz ref_clk and an 8-bit register port.
*/
package cfe_pkg;
  // Register map
  localparam logic [7:0] MAP_OFF       = 8'h20;
  localparam logic [7:0] MODE_OFF      = 8'h21;
  localparam logic [7:0] STAT_OFF      = 8'h35;
  localparam logic [7:0] MAP_RST       = 8'h00;
  localparam logic [7:0] MODE_RST      = 8'h03;
  localparam int         MAP_DIS_LSB   = 0;
  localparam int         MAP_SEL_LSB   = 4;
  localparam int         MODE_RR_LSB   = 0;
  localparam int         MODE_SYNC_LSB = 2;
  localparam int         STAT_PASS_BIT = 0;
  localparam int         STAT_SYNC_BIT = 1;
  localparam int         STAT_LOST_BIT = 2;

  // Sync window: about one line time
  localparam int          CLK_PERIOD_NS = 10;
  localparam int          WIN_NS        = 30000;
  localparam int          WIN_CYC       = WIN_NS / CLK_PERIOD_NS;
  localparam logic [11:0] WIN_CNT       = 12'(WIN_CYC);

  // Data path
  localparam int DATA_W     = 32;
  localparam int FIFO_W     = 33;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AFULL = FIFO_DEPTH - 2;

  typedef enum logic [1:0] {
    PK_FS    = 2'b00,
    PK_FE    = 2'b01,
    PK_LINE  = 2'b10,
    PK_OTHER = 2'b11
  } cfe_pkt_t;

  typedef enum logic [1:0] {
    SM_OFF   = 2'b00,
    SM_BASIC = 2'b01,
    SM_ILV   = 2'b10,
    SM_CAT   = 2'b11
  } cfe_smode_t;

  typedef enum logic [1:0] {
    ST_SEL  = 2'b00,
    ST_XFER = 2'b01,
    ST_DROP = 2'b10
  } cfe_fsm_t;
endpackage

// ===== design/cfe_engine.sv
/*
  CSI-2 forwarding engine for one transmitter: pulls whole packets from
  four per-port line buffers, round-robin or synchronized, through a
  32-word FIFO to the transmitter, with its control and status registers.
  Assumes buffers and transmitter share ref_clk and that the buffer
  depth is a power of two.
*/
`timescale 1ns/10ps
`default_nettype none

module cfe_fifo #(
  parameter int W = 33,
  parameter int D = 32
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready,
  output logic [$clog2(D):0] count
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } cfe_fifo_st_t;

  cfe_fifo_st_t r;
  cfe_fifo_st_t n;
  logic         push;
  logic         pop;

  assign in_ready  = r.cnt != (AW+1)'(D);
  assign out_valid = r.cnt != '0;
  assign out_data  = r.mem[r.rp];
  assign count     = r.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wp] = in_data;
      n.wp        = r.wp + 1'b1;
    end
    if (pop)
      n.rp = r.rp + 1'b1;
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      r <= '0;
    else if (ce)
      r <= n;
  end
endmodule

module cfe_engine #(
  parameter bit TX_ID = 1'b0
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         ce,
  // Register port
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic [7:0]        reg_rdata,
  // Per-port line buffers
  input  wire logic [3:0]   buf_pkt_avail,
  input  wire logic [7:0]   buf_pkt_type,
  input  wire logic [3:0]   buf_valid,
  input  wire logic [127:0] buf_data,
  input  wire logic [3:0]   buf_last,
  output logic [3:0]        buf_ready,
  // Transmitter
  output logic              tx_valid,
  output logic [31:0]       tx_data,
  output logic              tx_last,
  input  wire logic         tx_ready,
  output logic              tx_hs_req,
  // Status
  output logic              sync_status,
  output logic              sync_lost
);
  typedef struct packed {
    cfe_pkg::cfe_fsm_t fsm;
    logic [1:0]        cur;
    logic [1:0]        exp;
    logic              fwd;
    logic              hdr;
    logic [1:0]        rtype;
    logic [11:0]       tmr;
    logic              sync;
    logic              lost;
    logic [1:0]        smode;
    logic              rr;
    logic [3:0]        rdy;
    logic [7:0]        map;
    logic [7:0]        mode;
    logic [7:0]        rdata;
    logic              txv;
    logic [31:0]       txd;
    logic              txl;
    logic              hs;
  } cfe_st_t;

  cfe_st_t         r;
  cfe_st_t         n;
  logic [3:0]      en;
  logic [3:0][1:0] ptype;
  logic [3:0]      fs_head;
  logic            rr_on;
  logic [1:0]      sm;
  logic            sync_on;
  logic [1:0]      first;
  logic            is_last;
  logic            take;
  logic            strip;
  logic            cat_line;
  logic            fifo_wr;
  logic            fifo_in_rdy;
  logic            fifo_ov;
  logic [32:0]     fifo_q;
  logic            fifo_rd;
  logic [5:0]      fifo_cnt;
  logic            fail;

  function automatic logic [1:0] nxt_port(input logic [3:0] m, input logic [1:0] f);
    logic [1:0] p;
    nxt_port = f;
    for (int k = 4; k >= 1; k--)
    begin
      p = f + 2'(k);
      if (m[p])
        nxt_port = p;
    end
  endfunction

  for (genvar i = 0; i < 4; i++)
  begin : g_port
    // A port feeds this engine only when mapped here and not disabled
    assign en[i]      = !r.map[cfe_pkg::MAP_DIS_LSB+i] && (r.map[cfe_pkg::MAP_SEL_LSB+i] == TX_ID);
    assign ptype[i]   = buf_pkt_type[2*i +: 2];
    assign fs_head[i] = buf_pkt_avail[i] && (ptype[i] == cfe_pkg::PK_FS);
  end

  assign rr_on   = r.mode[cfe_pkg::MODE_RR_LSB + int'(TX_ID)];
  assign sm      = r.mode[cfe_pkg::MODE_SYNC_LSB + 2*int'(TX_ID) +: 2];
  assign sync_on = !rr_on && (sm != cfe_pkg::SM_OFF);
  assign first   = nxt_port(en, 2'd3);
  assign is_last = nxt_port(en, r.cur) <= r.cur;
  assign take    = (r.fsm == cfe_pkg::ST_XFER) && buf_valid[r.cur] && r.rdy[r.cur];
  // Only line packets are joined; FS and FE keep their own end word.
  // A miss in mid-line leaves the joined line open until the next FS.
  assign cat_line = sync_on && (sm == cfe_pkg::SM_CAT) && (r.rtype == cfe_pkg::PK_LINE);
  // Concatenation drops later ports' headers; the leading header keeps
  // its own word count, so the receiver sizes the line by position.
  assign strip   = cat_line && r.hdr && (r.cur != first);
  assign fifo_wr = take && r.fwd && !strip;
  assign fifo_rd = !r.txv || tx_ready;

  cfe_fifo #(
    .W (cfe_pkg::FIFO_W),
    .D (cfe_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .ce        (ce),
    .in_valid  (fifo_wr),
    .in_data   ({buf_last[r.cur] && !(cat_line && !is_last), buf_data[32*r.cur +: 32]}),
    .in_ready  (fifo_in_rdy),
    .out_valid (fifo_ov),
    .out_data  (fifo_q),
    .out_ready (fifo_rd),
    .count     (fifo_cnt)
  );

  always_comb
  begin
    n    = r;
    fail = 1'b0;
    if (reg_wr && reg_addr == cfe_pkg::MAP_OFF)
      n.map = reg_wdata;
    if (reg_wr && reg_addr == cfe_pkg::MODE_OFF)
      n.mode = reg_wdata;
    if (reg_rd)
    begin
      n.rdata = 8'h00;
      if (reg_addr == cfe_pkg::MAP_OFF)
        n.rdata = r.map;
      else if (reg_addr == cfe_pkg::MODE_OFF)
        n.rdata = r.mode;
      else if (reg_addr == cfe_pkg::STAT_OFF)
      begin
        n.rdata[cfe_pkg::STAT_PASS_BIT] = r.hs;
        n.rdata[cfe_pkg::STAT_SYNC_BIT] = r.sync && sync_on;
        n.rdata[cfe_pkg::STAT_LOST_BIT] = r.lost;
        n.lost = 1'b0;
      end
    end

    unique case (r.fsm)
      cfe_pkg::ST_SEL:
      begin
        if (r.smode != sm || r.rr != rr_on)
        begin
          // Mode is latched only between packets; cat_line and sync_on follow the register at once
          n.smode = sm;
          n.rr    = rr_on;
          n.sync  = 1'b0;
          n.exp   = first;
          n.fsm   = sync_on ? cfe_pkg::ST_DROP : cfe_pkg::ST_SEL;
        end
        else if (rr_on)
        begin
          if (|(en & buf_pkt_avail))
          begin
            n.cur = nxt_port(en & buf_pkt_avail, r.cur);
            n.fsm = cfe_pkg::ST_XFER;
            n.fwd = 1'b1;
            n.hdr = 1'b1;
          end
        end
        else if (sync_on && en[r.exp])
        begin
          if (buf_pkt_avail[r.exp])
          begin
            if (r.exp != first && ptype[r.exp] != r.rtype)
              fail = 1'b1;
            else
            begin
              n.cur   = r.exp;
              n.fsm   = cfe_pkg::ST_XFER;
              n.hdr   = 1'b1;
              n.rtype = ptype[r.exp];
              // Interleave and concatenation keep only the first port's FS/FE
              n.fwd   = !(sm != cfe_pkg::SM_BASIC && r.exp != first &&
                          (ptype[r.exp] == cfe_pkg::PK_FS || ptype[r.exp] == cfe_pkg::PK_FE));
            end
          end
          else if (r.exp != first)
          begin
            if (r.tmr == cfe_pkg::WIN_CNT)
              fail = 1'b1;
            else
              n.tmr = r.tmr + 12'h001;
          end
        end
        else if (sync_on)
          n.exp = first;
      end
      cfe_pkg::ST_XFER:
      begin
        if (take)
        begin
          n.hdr = 1'b0;
          if (buf_last[r.cur])
          begin
            n.exp = nxt_port(en, r.cur);
            if (r.cur == first)
              n.tmr = 12'h000;
            n.fsm = (sync_on && !r.sync) ? cfe_pkg::ST_DROP : cfe_pkg::ST_SEL;
          end
        end
      end
      cfe_pkg::ST_DROP:
      begin
        if (!sync_on || r.smode != sm)
          n.fsm = cfe_pkg::ST_SEL;
        else if (en != 4'h0 && (en & fs_head) == en)
        begin
          // Every enabled port holds a frame start: retry in step
          n.sync = 1'b1;
          n.fsm  = cfe_pkg::ST_SEL;
          n.exp  = first;
          n.tmr  = 12'h000;
        end
        else if (|(en & buf_pkt_avail & ~fs_head))
        begin
          n.cur = nxt_port(en & buf_pkt_avail & ~fs_head, 2'd3);
          n.fsm = cfe_pkg::ST_XFER;
          n.fwd = 1'b0;
          n.hdr = 1'b1;
        end
      end
      default:
        n.fsm = cfe_pkg::ST_SEL;
    endcase

    if (fail)
    begin
      n.fsm  = cfe_pkg::ST_DROP;
      n.sync = 1'b0;
      n.lost = 1'b1;
    end
    if (!sync_on)
      n.sync = 1'b0;

    // Ready looks at a count one cycle old, so keep two words of slack
    n.rdy = 4'h0;
    if (n.fsm == cfe_pkg::ST_XFER && (!n.fwd || int'(fifo_cnt) < cfe_pkg::FIFO_AFULL))
      n.rdy[n.cur] = 1'b1;

    if (fifo_rd)
    begin
      n.txv = fifo_ov;
      n.txd = fifo_q[31:0];
      n.txl = fifo_q[32];
    end
    n.hs = n.txv || fifo_ov;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      r      <= '0;
      r.map  <= cfe_pkg::MAP_RST;
      r.mode <= cfe_pkg::MODE_RST;
      r.rr   <= 1'b1;
    end
    else if (ce)
      r <= n;
  end

  assign reg_rdata   = r.rdata;
  assign buf_ready   = r.rdy;
  assign tx_valid    = r.txv;
  assign tx_data     = r.txd;
  assign tx_last     = r.txl;
  assign tx_hs_req   = r.hs;
  assign sync_status = r.sync;
  assign sync_lost   = r.lost;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn || !ce);

  a_start_whole_pkt: assert property ((r.fsm != cfe_pkg::ST_XFER && n.fsm == cfe_pkg::ST_XFER)
    |-> buf_pkt_avail[n.cur] && en[n.cur]) else $error("packet pulled before complete");
  a_port_disabled: assert property (r.fsm == cfe_pkg::ST_SEL && n.fsm == cfe_pkg::ST_XFER
    |-> !r.map[cfe_pkg::MAP_DIS_LSB + n.cur]) else $error("disabled port selected");
  a_sync_off_zero: assert property (!$past(sync_on) |-> !r.sync) else $error("sync status set while off");
  a_fail_sets_lost: assert property (fail |=> r.lost && r.fsm == cfe_pkg::ST_DROP && !r.sync)
    else $error("failure not recorded");
  a_read_clears: assert property (reg_rd && reg_addr == cfe_pkg::STAT_OFF && !fail |=> !r.lost)
    else $error("lost flag not cleared by read");
  a_discard_quiet: assert property (sync_on && !r.sync && !r.rr && r.smode == sm |-> !fifo_wr)
    else $error("word forwarded while unsynchronized");
  a_fifo_room: assert property (fifo_wr |-> fifo_in_rdy) else $error("buffer FIFO overrun");
  a_window_limit: assert property (sync_on && r.fsm == cfe_pkg::ST_SEL && r.tmr == cfe_pkg::WIN_CNT
    && r.smode == sm && !r.rr && en[r.exp] && !buf_pkt_avail[r.exp] && r.exp != first
    |=> r.fsm == cfe_pkg::ST_DROP) else $error("window expiry missed");
  a_sync_order: assert property (sync_on && r.sync && r.fsm == cfe_pkg::ST_SEL && n.fsm == cfe_pkg::ST_XFER
    |-> n.cur == r.exp ##1 (r.fsm == cfe_pkg::ST_XFER)[*1]) else $error("sync order broken");
  a_rr_rotate: assert property (rr_on && r.rr && r.smode == sm && r.fsm == cfe_pkg::ST_SEL && |(en & buf_pkt_avail)
    |=> r.fsm == cfe_pkg::ST_XFER) else $error("ready packet not served");
endmodule
`default_nettype wire

// ===== test/cfe_tx_sink.sv
/*
  Transmitter-side model for the forwarding engine: takes words and keeps
  the first word and the length of each packet it receives.
  Assumes the engine's outputs are registered on ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module cfe_tx_sink (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // Engine output
  input  wire logic        tx_valid,
  input  wire logic [31:0] tx_data,
  input  wire logic        tx_last,
  output logic             tx_ready,
  // Pace
  input  wire logic        slow
);
  logic [31:0] hdr[$];
  int          cnt[$];
  int          n = 0;
  logic [1:0]  ph = 2'h0;

  // Slow pace refuses two cycles in three so words back up in the FIFO
  always @(negedge ref_clk)
  begin
    ph = (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    tx_ready = resetn && (!slow || ph == 2'h0);
  end

  always @(posedge ref_clk)
    if (tx_valid && tx_ready)
    begin
      if (n == 0)
        hdr.push_back(tx_data);
      n++;
      if (tx_last)
      begin
        cnt.push_back(n);
        n = 0;
      end
    end
endmodule

`default_nettype wire

// ===== test/tb.sv
/*
  Testbench for the forwarding engine: register reads and writes, four
  modelled line buffers, and a transmitter model.
  Assumes cfe_pkg and the engine are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic         ref_clk, resetn, ce, reg_wr, reg_rd, slow;
  logic         tx_ready, tx_valid, tx_last, tx_hs_req, sync_status, sync_lost;
  logic [7:0]   reg_addr, reg_wdata, reg_rdata, buf_pkt_type, rd;
  logic [3:0]   buf_pkt_avail, buf_valid, buf_last, buf_ready, took;
  logic [127:0] buf_data;
  logic [31:0]  tx_data, exp_hdr[$];
  logic [1:0]   ptype[4];
  int           len[4], pos[4], exp_cnt[$], err_total, samples_checked, hs_bad;

  cfe_engine #(.TX_ID(1'b0)) cfe_engine_i (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .buf_pkt_avail(buf_pkt_avail), .buf_pkt_type(buf_pkt_type), .buf_valid(buf_valid),
    .buf_data(buf_data), .buf_last(buf_last), .buf_ready(buf_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .tx_hs_req(tx_hs_req),
    .sync_status(sync_status), .sync_lost(sync_lost));
  cfe_tx_sink cfe_tx_sink_i (.ref_clk(ref_clk), .resetn(resetn), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .slow(slow));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // Idle data lines toggle so a stale word cannot pass for a fresh one
  function automatic void drive();
    for (int i = 0; i < 4; i++)
    begin
      buf_pkt_avail[i] = len[i] != 0;
      buf_valid[i] = len[i] != 0;
      buf_last[i] = pos[i] == len[i] - 1;
      buf_pkt_type[2*i+:2] = ptype[i];
      buf_data[32*i+:32] = (len[i] != 0) ? {8'(i), 6'h0, ptype[i], 16'(pos[i])} : ~buf_data[32*i+:32];
    end
  endfunction

  always @(posedge ref_clk)
  begin
    took = buf_valid & buf_ready;
    if (tx_valid && !tx_hs_req)
      hs_bad++;
  end

  always @(negedge ref_clk)
  begin
    for (int i = 0; i < 4; i++)
      if (took[i] && len[i] != 0)
      begin
        pos[i]++;
        if (pos[i] == len[i])
          len[i] = 0;
      end
    drive();
  end

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd_reg(logic [7:0] a);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    rd = reg_rdata;
  endtask

  // Whole packets only: a port is loaded while its previous packet is gone
  task automatic offer(logic [3:0] m, logic [1:0] t, int n);
    @(negedge ref_clk);
    for (int i = 0; i < 4; i++)
      if (m[i])
      begin
        len[i] = n;
        pos[i] = 0;
        ptype[i] = t;
        took[i] = 1'b0;
      end
    drive();
  endtask

  task automatic settle(logic [3:0] m);
    int q;
    int busy;
    q = 0;
    for (int k = 0; k < 4000 && q < 8; k++)
    begin
      @(negedge ref_clk);
      busy = 0;
      for (int i = 0; i < 4; i++)
        if (m[i] && len[i] != 0)
          busy = 1;
      q = (busy == 0 && !tx_valid) ? q + 1 : 0;
    end
    check("settle", 32'(q), 32'd8);
  endtask

  function automatic void want(int p, logic [1:0] t, int n);
    exp_hdr.push_back({8'(p), 6'h0, t, 16'h0});
    exp_cnt.push_back(n);
  endfunction

  task automatic compare_out(string what);
    check({what, " count"}, 32'(cfe_tx_sink_i.hdr.size()), 32'(exp_hdr.size()));
    foreach (exp_hdr[k])
    begin
      check({what, " header"}, cfe_tx_sink_i.hdr[k], exp_hdr[k]);
      check({what, " length"}, 32'(cfe_tx_sink_i.cnt[k]), 32'(exp_cnt[k]));
    end
    exp_hdr.delete();
    exp_cnt.delete();
    cfe_tx_sink_i.hdr.delete();
    cfe_tx_sink_i.cnt.delete();
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    close_out();
  end

  initial
  begin
    {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, buf_data, took} = '0;
    ce = 1'b1;
    slow = 1'b1;
    drive();
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    rd_reg(8'h20);
    check("map reset", 32'(rd), 32'h00);
    rd_reg(8'h21);
    check("mode reset", 32'(rd), 32'h03);
    wr(8'h35, 8'hff);
    rd_reg(8'h35);
    check("status idle", 32'(rd & 8'h07), 32'h00);
    rd_reg(8'h55);
    check("unmapped", 32'(rd), 32'h00);
    // Rotation restarts after the last port served
    offer(4'h4, cfe_pkg::PK_LINE, 3);
    settle(4'hf);
    offer(4'hf, cfe_pkg::PK_OTHER, 2);
    settle(4'hf);
    want(2, cfe_pkg::PK_LINE, 3);
    for (int p = 3; p < 7; p++)
      want(p % 4, cfe_pkg::PK_OTHER, 2);
    compare_out("round robin");
    wr(8'h20, 8'h24);
    rd_reg(8'h20);
    check("map", 32'(rd), 32'h24);
    offer(4'hf, cfe_pkg::PK_LINE, 3);
    settle(4'h9);
    check("held ports", 32'(pos[1] + pos[2]), 32'h0);
    want(3, cfe_pkg::PK_LINE, 3);
    want(0, cfe_pkg::PK_LINE, 3);
    wr(8'h20, 8'h00);
    settle(4'hf);
    want(1, cfe_pkg::PK_LINE, 3);
    want(2, cfe_pkg::PK_LINE, 3);
    compare_out("port control");
    for (int m = 3; m > 0; m--)
    begin
      wr(8'h21, 8'h00);
      wr(8'h20, 8'h00);
      wr(8'h21, 8'(m << 2));
      offer(4'hf, cfe_pkg::PK_FS, 1);
      settle(4'hf);
      check("sync out", 32'(sync_status), 32'h1);
      rd_reg(8'h35);
      check("sync bit", 32'(rd & 8'h06), 32'h02);
      offer(4'hf, cfe_pkg::PK_LINE, 3);
      settle(4'hf);
      offer(4'hf, cfe_pkg::PK_FE, 1);
      settle(4'hf);
      for (int p = 0; p < 4; p++)
        if (m == 1 || p == 0)
          want(p, cfe_pkg::PK_FS, 1);
      for (int p = 0; p < 4; p++)
        if (m != 3)
          want(p, cfe_pkg::PK_LINE, 3);
      if (m == 3)
        want(0, cfe_pkg::PK_LINE, 9);
      for (int p = 0; p < 4; p++)
        if (m == 1 || p == 0)
          want(p, cfe_pkg::PK_FE, 1);
      compare_out("sync order");
    end
    // Only port 0 offers a line: port 1 misses the window
    offer(4'h1, cfe_pkg::PK_LINE, 3);
    for (int k = 0; k < 3200 && sync_lost !== 1'b1; k++)
      @(negedge ref_clk);
    check("lost out", 32'({sync_lost, sync_status}), 32'h2);
    // The first port's line leaves before the miss is known; later lines drop
    offer(4'h1, cfe_pkg::PK_LINE, 3);
    settle(4'h1);
    want(0, cfe_pkg::PK_LINE, 3);
    compare_out("discard");
    rd_reg(8'h35);
    check("lost bit", 32'(rd & 8'h06), 32'h04);
    rd_reg(8'h35);
    check("lost cleared", 32'(rd & 8'h06), 32'h00);
    offer(4'hf, cfe_pkg::PK_FS, 1);
    settle(4'hf);
    for (int p = 0; p < 4; p++)
      want(p, cfe_pkg::PK_FS, 1);
    compare_out("resync");
    check("resync out", 32'(sync_status), 32'h1);
    wr(8'h21, 8'h03);
    rd_reg(8'h35);
    check("sync off", 32'(rd & 8'h02), 32'h00);
    check("hs request", 32'(hs_bad), 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
